// >>> design/sbm_map.svh
// Register offsets, field positions, reset values and timing counts for the serial byte master
`ifndef SBM_MAP_SVH
`define SBM_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define SBM_OFF_DATA 8'hB0
`define SBM_OFF_INDEX 8'hB1
`define SBM_OFF_TADDR 8'hB2
`define SBM_OFF_CTRL 8'hB3

// ****************************************
// Control and status field positions
// ****************************************
`define SBM_CTRL_SHORT 7
`define SBM_CTRL_BUSY 5
`define SBM_CTRL_TEST 2
`define SBM_CTRL_ERR 1
`define SBM_TADDR_DIR 0

// ****************************************
// Reset values
// ****************************************
`define SBM_RST_BYTE 8'h00
`define SBM_RST_BIT 1'b0

// ****************************************
// Serial clock timing
// ****************************************
`define SBM_SCL_PERIOD_NS 10000
`define SBM_LINK_PERIOD_NS 160
`define SBM_QTR_CYC (`SBM_SCL_PERIOD_NS / (4 * `SBM_LINK_PERIOD_NS))
`define SBM_FAST_DIV 4
`define SBM_QTR_CYC_FAST (`SBM_QTR_CYC / `SBM_FAST_DIV)

// ****************************************
// Bit and phase positions
// ****************************************
`define SBM_BIT_ACK 4'h8
`define SBM_Q_DRIVE 2'h0
`define SBM_Q_RISE 2'h1
`define SBM_Q_SAMPLE 2'h2
`define SBM_Q_FALL 2'h3

`endif

// >>> design/sbm_pkg.sv
// Types shared by the serial byte master
package sbm_pkg;

	// ****************************************
	// Link state machine, one-hot
	// ****************************************
	typedef enum logic [3:0] {
		SBM_L_IDLE = 4'h1,
		SBM_L_START = 4'h2,
		SBM_L_BYTE = 4'h4,
		SBM_L_STOP = 4'h8
	} sbm_lst_e;

	// ****************************************
	// Which byte of the transfer is on the wire
	// ****************************************
	typedef enum logic [1:0] {
		SBM_SEQ_ADDR = 2'h0,
		SBM_SEQ_IDX = 2'h1,
		SBM_SEQ_DATA = 2'h2,
		SBM_SEQ_RADDR = 2'h3
	} sbm_seq_e;

endpackage

// >>> design/sbm_sync.sv
// Two-flop synchroniser for levels and toggles
`timescale 1ns/1ps

module sbm_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;

endmodule // sbm_sync

// >>> design/sbm_top.sv
// Software-driven byte read/write master for a two-wire serial bus
//
// Behaviour
// - Data register holds byte sent on writes and byte received on reads.
// - Index register is sent as the byte address inside the target.
// - Target address bits 7..1 select the slave for the transfer.
// - Bit 0 is the direction bit: 0 byte write, 1 byte read.
// - Received byte lands in the data register on the same mclk edge that clears busy.
// - Writing target address sets busy and starts one transfer; busy holds meanwhile.
// - Missing acknowledge sets a sticky error flag; writing 1 clears it.
// - Short protocol select drops the byte-address phase.
// - Serial clock near 100 kHz; a test bit makes it faster.
`timescale 1ns/1ps
`include "sbm_map.svh"

module sbm_top #(
	parameter int CNT_W = 4
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	input wire logic link_clk,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);

	// ****************************************
	// Register side, mclk domain
	// ****************************************
	logic [7:0] data_reg;
	logic [7:0] index_reg;
	logic [7:0] taddr_reg;
	logic short_reg;
	logic test_reg;
	logic busy_reg;
	logic err_reg;
	logic req_short_reg;
	logic req_test_reg;
	logic req_tgl_reg;
	logic done_d_reg;
	logic [7:0] rdata_reg;
	logic done_s;

	// Link results, held stable from done toggle until next request
	logic [7:0] res_byte_reg;
	logic res_err_reg;
	logic done_tgl_reg;

	// Writes to the transfer registers are dropped while busy so the
	// link never sees its request words change under it
	wire hit_data = cfg_addr == `SBM_OFF_DATA;
	wire hit_index = cfg_addr == `SBM_OFF_INDEX;
	wire hit_taddr = cfg_addr == `SBM_OFF_TADDR;
	wire hit_ctrl = cfg_addr == `SBM_OFF_CTRL;
	wire wr_data = cfg_wr && hit_data && !busy_reg;
	wire wr_index = cfg_wr && hit_index && !busy_reg;
	wire start = cfg_wr && hit_taddr && !busy_reg;
	wire wr_ctrl = cfg_wr && hit_ctrl;
	wire err_clr = wr_ctrl && cfg_wdata[`SBM_CTRL_ERR];
	wire done_evt = done_s ^ done_d_reg;
	wire rd_dir = taddr_reg[`SBM_TADDR_DIR];
	wire load_rx = done_evt && rd_dir && !res_err_reg;

	wire [7:0] data_next = wr_data ? cfg_wdata : (load_rx ? res_byte_reg : data_reg);
	wire [7:0] index_next = wr_index ? cfg_wdata : index_reg;
	wire [7:0] taddr_next = start ? cfg_wdata : taddr_reg;
	wire busy_next = start ? 1'b1 : (done_evt ? 1'b0 : busy_reg);
	wire err_next = (done_evt && res_err_reg) || (err_reg && !err_clr);
	wire short_next = wr_ctrl ? cfg_wdata[`SBM_CTRL_SHORT] : short_reg;
	wire test_next = wr_ctrl ? cfg_wdata[`SBM_CTRL_TEST] : test_reg;

	wire [7:0] ctrl_view = {short_reg, 1'b0, busy_reg, 2'b00, test_reg, err_reg, 1'b0};
	wire [7:0] rd_mux = hit_data ? data_reg :
		hit_index ? index_reg :
		hit_taddr ? taddr_reg :
		hit_ctrl ? ctrl_view : `SBM_RST_BYTE;
	wire [7:0] rdata_next = cfg_rd ? rd_mux : rdata_reg;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			data_reg <= `SBM_RST_BYTE;
			index_reg <= `SBM_RST_BYTE;
			taddr_reg <= `SBM_RST_BYTE;
			rdata_reg <= `SBM_RST_BYTE;
		end else begin
			data_reg <= data_next;
			index_reg <= index_next;
			taddr_reg <= taddr_next;
			rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			short_reg <= `SBM_RST_BIT;
			test_reg <= `SBM_RST_BIT;
			busy_reg <= `SBM_RST_BIT;
			err_reg <= `SBM_RST_BIT;
			done_d_reg <= `SBM_RST_BIT;
		end else begin
			short_reg <= short_next;
			test_reg <= test_next;
			busy_reg <= busy_next;
			err_reg <= err_next;
			done_d_reg <= done_s;
		end
	end

	// Mode bits are frozen per transfer; software may rewrite them while busy
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			req_short_reg <= `SBM_RST_BIT;
			req_test_reg <= `SBM_RST_BIT;
			req_tgl_reg <= `SBM_RST_BIT;
		end else if (start) begin
			req_short_reg <= short_reg;
			req_test_reg <= test_reg;
			req_tgl_reg <= !req_tgl_reg;
		end
	end

	assign cfg_rdata = rdata_reg;

	// ****************************************
	// Crossings
	// ****************************************
	logic req_s;
	logic sda_s;

	sbm_sync #(.WIDTH(1)) u_req_sync (.clk(link_clk), .rst_n(rst_n), .d(req_tgl_reg), .q(req_s));
	sbm_sync #(.WIDTH(1)) u_done_sync (.clk(mclk), .rst_n(rst_n), .d(done_tgl_reg), .q(done_s));
	sbm_sync #(.WIDTH(1)) u_sda_sync (.clk(link_clk), .rst_n(rst_n), .d(sda_i), .q(sda_s));

	// ****************************************
	// Link side, link_clk domain
	// ****************************************
	sbm_pkg::sbm_lst_e lst_reg, lst_next;
	sbm_pkg::sbm_seq_e seq_reg, seq_next;
	logic [1:0] q_reg, q_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] shift_reg, shift_next;
	logic rx_reg, rx_next;
	logic rstart_reg, rstart_next;
	logic nack_reg, nack_next;
	logic req_seen_reg, req_seen_next;
	logic scl_oe_reg, scl_oe_next;
	logic sda_oe_reg, sda_oe_next;
	logic [7:0] res_byte_next;
	logic res_err_next;
	logic done_tgl_next;
	logic scl_o_reg;
	logic sda_o_reg;

	// Clock stretching by the slave is not honoured
	wire [CNT_W-1:0] qtr_load = req_test_reg ? CNT_W'(`SBM_QTR_CYC_FAST - 1) :
		CNT_W'(`SBM_QTR_CYC - 1);
	wire tick = cnt_reg == '0;
	wire new_req = req_s ^ req_seen_reg;
	wire tx_read = taddr_reg[`SBM_TADDR_DIR];
	wire [6:0] tgt = taddr_reg[7:1];
	wire ack_bit = bit_reg == `SBM_BIT_ACK;

	always_comb begin
		lst_next = lst_reg;
		seq_next = seq_reg;
		q_next = q_reg;
		cnt_next = (lst_reg == sbm_pkg::SBM_L_IDLE || tick) ? qtr_load : cnt_reg - 1'b1;
		bit_next = bit_reg;
		shift_next = shift_reg;
		rx_next = rx_reg;
		rstart_next = rstart_reg;
		nack_next = nack_reg;
		req_seen_next = req_seen_reg;
		scl_oe_next = scl_oe_reg;
		sda_oe_next = sda_oe_reg;
		res_byte_next = res_byte_reg;
		res_err_next = res_err_reg;
		done_tgl_next = done_tgl_reg;
		unique case (lst_reg)
			sbm_pkg::SBM_L_IDLE: begin
				if (new_req) begin
					req_seen_next = req_s;
					lst_next = sbm_pkg::SBM_L_START;
					q_next = `SBM_Q_DRIVE;
					rstart_next = 1'b0;
					res_err_next = 1'b0;
				end
			end
			sbm_pkg::SBM_L_START: begin
				// Release both lines, then pull data low while clock is high
				if (tick) begin
					q_next = q_reg + 1'b1;
					unique case (q_reg)
						`SBM_Q_DRIVE: sda_oe_next = 1'b0;
						`SBM_Q_RISE: scl_oe_next = 1'b0;
						`SBM_Q_SAMPLE: sda_oe_next = 1'b1;
						`SBM_Q_FALL: begin
							scl_oe_next = 1'b1;
							lst_next = sbm_pkg::SBM_L_BYTE;
							bit_next = '0;
							rx_next = 1'b0;
							if (rstart_reg || (req_short_reg && tx_read)) begin
								shift_next = {tgt, 1'b1};
								seq_next = sbm_pkg::SBM_SEQ_RADDR;
							end else begin
								shift_next = {tgt, 1'b0};
								seq_next = sbm_pkg::SBM_SEQ_ADDR;
							end
						end
					endcase
				end
			end
			sbm_pkg::SBM_L_BYTE: begin
				if (tick) begin
					q_next = q_reg + 1'b1;
					unique case (q_reg)
						// Receive and the closing not-acknowledge leave data released
						`SBM_Q_DRIVE: sda_oe_next = !rx_reg && !ack_bit && !shift_reg[7];
						`SBM_Q_RISE: scl_oe_next = 1'b0;
						`SBM_Q_SAMPLE: begin
							if (!ack_bit)
								shift_next = {shift_reg[6:0], sda_s};
							else
								nack_next = sda_s;
						end
						`SBM_Q_FALL: begin
							scl_oe_next = 1'b1;
							if (!ack_bit) begin
								bit_next = bit_reg + 1'b1;
							end else if (rx_reg) begin
								res_byte_next = shift_reg;
								lst_next = sbm_pkg::SBM_L_STOP;
							end else if (nack_reg) begin
								res_err_next = 1'b1;
								lst_next = sbm_pkg::SBM_L_STOP;
							end else begin
								bit_next = '0;
								unique case (seq_reg)
									sbm_pkg::SBM_SEQ_ADDR: begin
										if (req_short_reg) begin
											shift_next = data_reg;
											seq_next = sbm_pkg::SBM_SEQ_DATA;
										end else begin
											shift_next = index_reg;
											seq_next = sbm_pkg::SBM_SEQ_IDX;
										end
									end
									sbm_pkg::SBM_SEQ_IDX: begin
										if (tx_read) begin
											rstart_next = 1'b1;
											lst_next = sbm_pkg::SBM_L_START;
										end else begin
											shift_next = data_reg;
											seq_next = sbm_pkg::SBM_SEQ_DATA;
										end
									end
									sbm_pkg::SBM_SEQ_DATA: lst_next = sbm_pkg::SBM_L_STOP;
									sbm_pkg::SBM_SEQ_RADDR: rx_next = 1'b1;
								endcase
							end
						end
					endcase
				end
			end
			sbm_pkg::SBM_L_STOP: begin
				// Data rises while clock is high; done only after the line is free
				if (tick) begin
					q_next = q_reg + 1'b1;
					unique case (q_reg)
						`SBM_Q_DRIVE: sda_oe_next = 1'b1;
						`SBM_Q_RISE: scl_oe_next = 1'b0;
						`SBM_Q_SAMPLE: sda_oe_next = 1'b0;
						`SBM_Q_FALL: begin
							lst_next = sbm_pkg::SBM_L_IDLE;
							done_tgl_next = !done_tgl_reg;
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			lst_reg <= sbm_pkg::SBM_L_IDLE;
			seq_reg <= sbm_pkg::SBM_SEQ_ADDR;
			q_reg <= `SBM_Q_DRIVE;
			cnt_reg <= '0;
			bit_reg <= '0;
			shift_reg <= `SBM_RST_BYTE;
		end else begin
			lst_reg <= lst_next;
			seq_reg <= seq_next;
			q_reg <= q_next;
			cnt_reg <= cnt_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
		end
	end

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_reg <= `SBM_RST_BIT;
			rstart_reg <= `SBM_RST_BIT;
			nack_reg <= `SBM_RST_BIT;
			req_seen_reg <= `SBM_RST_BIT;
			res_byte_reg <= `SBM_RST_BYTE;
			res_err_reg <= `SBM_RST_BIT;
			done_tgl_reg <= `SBM_RST_BIT;
		end else begin
			rx_reg <= rx_next;
			rstart_reg <= rstart_next;
			nack_reg <= nack_next;
			req_seen_reg <= req_seen_next;
			res_byte_reg <= res_byte_next;
			res_err_reg <= res_err_next;
			done_tgl_reg <= done_tgl_next;
		end
	end

	// Open-drain pins: the driven level is always low
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_oe_reg <= `SBM_RST_BIT;
			sda_oe_reg <= `SBM_RST_BIT;
			scl_o_reg <= `SBM_RST_BIT;
			sda_o_reg <= `SBM_RST_BIT;
		end else begin
			scl_oe_reg <= scl_oe_next;
			sda_oe_reg <= sda_oe_next;
			scl_o_reg <= `SBM_RST_BIT;
			sda_o_reg <= `SBM_RST_BIT;
		end
	end

	assign scl_oe = scl_oe_reg;
	assign sda_oe = sda_oe_reg;
	assign scl_o = scl_o_reg;
	assign sda_o = sda_o_reg;

	// ****************************************
	// Assertions
	// ****************************************
	busy_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
		start |=> busy_reg && req_tgl_reg != $past(req_tgl_reg)) else $error("busy not set");
	busy_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		busy_reg && !done_evt |=> busy_reg) else $error("busy dropped early");
	err_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
		done_evt && res_err_reg |=> err_reg && !busy_reg) else $error("error not flagged");
	err_clr_a: assert property (@(posedge mclk) disable iff (!rst_n)
		err_clr && !done_evt |=> !err_reg) else $error("error not cleared");
	rd_data_a: assert property (@(posedge mclk) disable iff (!rst_n)
		load_rx |=> data_reg == $past(res_byte_reg) && !busy_reg) else $error("read data lost");
	data_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_data ##1 !wr_data && !done_evt |=> data_reg == $past(cfg_wdata, 2))
		else $error("data write lost");
	addr_byte_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		lst_reg == sbm_pkg::SBM_L_BYTE && $changed(seq_reg) && seq_reg != sbm_pkg::SBM_SEQ_DATA
		&& seq_reg != sbm_pkg::SBM_SEQ_IDX |-> shift_reg[7:1] == tgt
		&& shift_reg[0] == (seq_reg == sbm_pkg::SBM_SEQ_RADDR)) else $error("bad address byte");
	idx_byte_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		$rose(seq_reg == sbm_pkg::SBM_SEQ_IDX) |-> shift_reg == index_reg && !req_short_reg)
		else $error("bad index byte");
	short_skip_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		req_short_reg && lst_reg != sbm_pkg::SBM_L_IDLE |-> seq_reg != sbm_pkg::SBM_SEQ_IDX)
		else $error("index sent in short mode");
	tick_len_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		lst_reg != sbm_pkg::SBM_L_IDLE && tick |=> cnt_reg == qtr_load) else $error("bad rate");
	sda_stable_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		lst_reg == sbm_pkg::SBM_L_BYTE && $changed(sda_oe_reg) |-> scl_oe_reg)
		else $error("data moved with clock high");

	write_c: cover property (@(posedge mclk) disable iff (!rst_n) done_evt && !rd_dir);
	read_c: cover property (@(posedge mclk) disable iff (!rst_n) load_rx);
	error_c: cover property (@(posedge mclk) disable iff (!rst_n) done_evt && res_err_reg);
	short_c: cover property (@(posedge link_clk) disable iff (!rst_n)
		req_short_reg && rx_reg && lst_reg == sbm_pkg::SBM_L_STOP);

endmodule // sbm_top

// >>> verif/sbm_eeprom_model.sv
// Behavioural serial-bus slave memory facing the serial byte master
`timescale 1ns/1ps

module sbm_eeprom_model #(
	parameter logic [6:0] DEV_ADDR = 7'h50
) (
	input wire logic scl,
	input wire logic sda,
	output logic sda_pull,
	output logic [7:0] last_rx,
	output logic [7:0] rx_count
);
	logic [7:0] mem [0:255];
	logic [7:0] sr;
	logic [7:0] ptr;
	logic active;
	logic rd;
	logic tx;
	int bit_n;
	int byte_n;

	// ****************************************
	// Power-up contents
	// ****************************************
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'hA5;
		end
		sda_pull = 1'b0;
		active = 1'b0;
		tx = 1'b0;
		rd = 1'b0;
		ptr = 8'h00;
		last_rx = 8'h00;
		rx_count = 8'h00;
	end

	// ****************************************
	// Start and stop detection
	// ****************************************
	// Pointer survives a repeated start, as on a real memory
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			active = 1'b1;
			tx = 1'b0;
			bit_n = -1;
			byte_n = 0;
			sda_pull = 1'b0;
		end
	end
	always @(posedge sda) begin
		if (scl === 1'b1) begin
			active = 1'b0;
			sda_pull = 1'b0;
		end
	end

	// ****************************************
	// Bit engine, no clock stretching
	// ****************************************
	always @(posedge scl) begin
		if (active && bit_n >= 0 && bit_n < 8 && !tx) begin
			sr = {sr[6:0], sda};
		end else if (active && bit_n == 8 && tx && sda === 1'b1) begin
			active = 1'b0;
		end
	end
	always @(negedge scl) begin
		if (active) begin
			bit_n = bit_n + 1;
			if (bit_n == 9) begin
				bit_n = 0;
				sda_pull = 1'b0;
				byte_n = byte_n + 1;
				if (rd && !tx) begin
					tx = 1'b1;
					sr = mem[ptr];
					sda_pull = ~sr[7];
				end
			end else if (tx) begin
				sda_pull = (bit_n < 8) ? ~sr[7 - bit_n] : 1'b0;
			end else if (bit_n == 8) begin
				last_rx = sr;
				rx_count = 8'(byte_n + 1);
				if (byte_n == 0) begin
					rd = sr[0];
					// Foreign address: no acknowledge, line stays released
					if (sr[7:1] !== DEV_ADDR) begin
						active = 1'b0;
					end else begin
						sda_pull = 1'b1;
					end
				end else begin
					if (byte_n == 1) begin
						ptr = sr;
					end else begin
						mem[ptr] = sr;
						ptr = ptr + 8'h01;
					end
					sda_pull = 1'b1;
				end
			end
		end
	end
endmodule // sbm_eeprom_model

// >>> verif/sbm_top_bench.sv
// Self-checking testbench for the serial byte master
`timescale 1ns/1ps
`include "sbm_map.svh"

module sbm_top_bench;
	localparam logic [6:0] DEV = 7'h50;
	logic mclk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_n = 1'b1;
	logic [7:0] cfg_addr = 8'h00;
	logic cfg_wr = 1'b0;
	logic cfg_rd = 1'b0;
	logic [7:0] cfg_wdata = 8'h00;
	logic [7:0] cfg_rdata;
	logic scl_o;
	logic scl_oe;
	logic sda_o;
	logic sda_oe;
	logic slv_pull;
	logic [7:0] slv_last;
	logic [7:0] slv_cnt;
	wire logic scl_w = ~scl_oe;
	wire logic sda_w = ~(sda_oe | slv_pull);
	int n_mismatch = 0;
	int total_checks = 0;
	realtime t_rise = 0.0;
	realtime min_per = 1.0e9;

	// ****************************************
	// Clocks and serial clock period monitor
	// ****************************************
	always #10 mclk = ~mclk;
	initial begin
		#37;
		forever #80 link_clk = ~link_clk;
	end
	always @(posedge scl_w) begin
		if ($realtime - t_rise < min_per) min_per = $realtime - t_rise;
		t_rise = $realtime;
	end

	sbm_top #(.CNT_W(4)) i_dut (.mclk(mclk), .rst_n(rst_n), .cfg_addr(cfg_addr),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.link_clk(link_clk), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe(sda_oe));
	sbm_eeprom_model #(.DEV_ADDR(DEV)) i_slave (.scl(scl_w), .sda(sda_w),
		.sda_pull(slv_pull), .last_rx(slv_last), .rx_count(slv_cnt));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		cfg_addr = a;
		cfg_wdata = d;
		cfg_wr = 1'b1;
		@(posedge mclk);
		#1;
		cfg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		#1;
		cfg_addr = a;
		cfg_rd = 1'b1;
		@(posedge mclk);
		#1;
		cfg_rd = 1'b0;
		d = cfg_rdata;
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(what, exp, d);
	endtask
	// Poke stands for a late software write that must be dropped while busy
	task automatic xfer(input logic [7:0] ta, input logic poke);
		logic [7:0] s;
		int n;
		min_per = 1.0e9;
		wr(`SBM_OFF_TADDR, ta);
		if (poke) wr(`SBM_OFF_DATA, 8'hFF);
		rd(`SBM_OFF_CTRL, s);
		chk("busy set", 8'h01, {7'h00, s[`SBM_CTRL_BUSY]});
		n = 0;
		while (s[`SBM_CTRL_BUSY] !== 1'b0 && n < 20000) begin
			rd(`SBM_OFF_CTRL, s);
			n++;
		end
		chk("busy clear", 8'h00, {7'h00, s[`SBM_CTRL_BUSY]});
		chk("bus released", 8'h00, {6'h00, scl_oe, sda_oe});
		chk("drive level", 8'h00, {6'h00, scl_o, sda_o});
	endtask
	function automatic logic [7:0] quarter();
		return 8'($rtoi(min_per) / 640);
	endfunction

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		rchk("data reset", `SBM_OFF_DATA, 8'h00);
		rchk("index reset", `SBM_OFF_INDEX, 8'h00);
		rchk("taddr reset", `SBM_OFF_TADDR, 8'h00);
		rchk("ctrl reset", `SBM_OFF_CTRL, 8'h00);
		wr(`SBM_OFF_DATA, 8'hC3);
		wr(`SBM_OFF_INDEX, 8'h3C);
		wr(8'hB7, 8'hFF);
		rchk("data rw", `SBM_OFF_DATA, 8'hC3);
		rchk("index rw", `SBM_OFF_INDEX, 8'h3C);
		rchk("unmapped", 8'hB7, 8'h00);
	endtask
	task automatic t_write;
		wr(`SBM_OFF_CTRL, 8'h04);
		wr(`SBM_OFF_DATA, 8'h3C);
		wr(`SBM_OFF_INDEX, 8'h12);
		xfer({DEV, 1'b0}, 1'b1);
		chk("slave memory", 8'h3C, i_slave.mem[8'h12]);
		chk("write bytes", 8'h03, slv_cnt);
		chk("fast quarter", 8'h03, quarter());
		rchk("data kept", `SBM_OFF_DATA, 8'h3C);
		rchk("taddr rb", `SBM_OFF_TADDR, {DEV, 1'b0});
		rchk("no error", `SBM_OFF_CTRL, 8'h04);
	endtask
	task automatic t_read;
		wr(`SBM_OFF_INDEX, 8'h12);
		xfer({DEV, 1'b1}, 1'b0);
		rchk("read back", `SBM_OFF_DATA, 8'h3C);
		chk("read bytes", 8'h01, slv_cnt);
		wr(`SBM_OFF_INDEX, 8'h40);
		xfer({DEV, 1'b1}, 1'b0);
		rchk("read fresh", `SBM_OFF_DATA, 8'hE5);
	endtask
	task automatic t_short;
		wr(`SBM_OFF_CTRL, 8'h84);
		wr(`SBM_OFF_DATA, 8'h33);
		xfer({DEV, 1'b0}, 1'b0);
		chk("short bytes", 8'h02, slv_cnt);
		chk("short byte", 8'h33, slv_last);
		// Sent byte became the slave pointer; its cell differs from an idle line
		xfer({DEV, 1'b1}, 1'b0);
		rchk("short read", `SBM_OFF_DATA, 8'h96);
	endtask
	task automatic t_error;
		wr(`SBM_OFF_CTRL, 8'h04);
		wr(`SBM_OFF_DATA, 8'h77);
		xfer({DEV ^ 7'h01, 1'b1}, 1'b0);
		rchk("error set", `SBM_OFF_CTRL, 8'h06);
		rchk("data untouched", `SBM_OFF_DATA, 8'h77);
		xfer({DEV, 1'b0}, 1'b0);
		rchk("error sticky", `SBM_OFF_CTRL, 8'h06);
		wr(`SBM_OFF_CTRL, 8'h06);
		rchk("error cleared", `SBM_OFF_CTRL, 8'h04);
	endtask
	task automatic t_slow;
		wr(`SBM_OFF_CTRL, 8'h80);
		xfer({DEV, 1'b0}, 1'b0);
		chk("normal quarter", 8'h0F, quarter());
	endtask

	// ****************************************
	// Verdict and run control
	// ****************************************
	task automatic end_sim;
		$display("Checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		n_mismatch++;
		end_sim();
	end
	// Early falling edge clears both domains at once, link clock or not
	initial begin
		#1;
		rst_n = 1'b0;
		repeat (4) @(posedge mclk);
		chk("idle in reset", 8'h00, {6'h00, scl_oe, sda_oe});
		repeat (2) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		t_regs();
		t_write();
		t_read();
		t_short();
		t_error();
		t_slow();
		end_sim();
	end
endmodule // sbm_top_bench
